// ### rtl/enc_div_defines.svh
// constants of the encoder pulse divider and motorless test block
// assumes a 100 MHz ref_clk and an axi4-lite master with 32-bit data
// Behaviour
// RULE1 - resolution 1..4096, default 20, takes effect only after restart
// RULE2 - scale feedback edges per pitch are divided by the resolution
// RULE3 - upper limit is pitch / 100 / max speed * 72
// RULE4 - setting alarm when resolution out of range or above limit
// RULE5 - overspeed alarm when motor speed exceeds resolution-implied limit
// RULE6 - pitch 2000, max speed 50: 28 accepted, 29 flagged
// RULE7 - resolution counts quadrature edges, 20 gives five a/b cycles
// RULE8 - origin pulse at two positions for direction-dependent zero point
// RULE9 - direct scale: pitch setting ignored, scale pitch shown on monitors
// RULE10 - max speed capped for 4 um pitch
// RULE11 - test digit 0 = 1 enables motorless test after restart
// RULE12 - test digit 2 selects incremental (0) or absolute (1) scale
// RULE13 - simulated encoder type used only with no motor connected
// RULE14 - no regeneration, dynamic brake or brake output in test
// RULE15 - refuse offset/origin without motor, tuning functions always in test
// RULE16 - outputs a and b are a quadrature pair 90 degrees apart
// RULE17 - origin pulse width equals one phase a pulse
// RULE18 - divider cleared and outputs static in reset or setting alarm
`ifndef ENC_DIV_DEFINES_SVH
`define ENC_DIV_DEFINES_SVH
`define A_CTRL 8'h00
`define A_RES 8'h04
`define A_PITCH 8'h08
`define A_MAXSPD 8'h0c
`define A_TESTCFG 8'h10
`define A_STATUS 8'h14
`define A_MASK 8'h18
`define A_STATE 8'h1c
`define A_PMON_LO 8'h20
`define A_PMON_HI 8'h24
`define RES_MIN 13'h0001
`define RES_MAX 13'h1000
`define RES_RST 13'h0014
`define PITCH_RST 16'h07d0
`define MAXSPD_RST 16'h0032
`define TESTCFG_RST 16'h0000
`define LIM_DIV 48'h64
`define LIM_MUL 48'h48
`define PITCH_4UM 32'h0000_0190
`define SPD_CAP_4UM 16'h000a
`define ST_SET 0
`define ST_OVS 1
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// ### rtl/enc_div_pkg.sv
// types of the encoder pulse divider block
// assumes nothing beyond the defines header
package enc_div_pkg;
  typedef enum logic [1:0] {
    ORG_IDLE = 2'b01,
    ORG_ACTIVE = 2'b10
  } org_state_t;
endpackage

// ### rtl/enc_div.sv
// encoder pulse divider with quadrature re-output and motorless test mode
// assumes scale, motor and function inputs are synchronous to ref_clk
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "enc_div_defines.svh"
module enc_div
  import enc_div_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // scale feedback
  input wire logic fb_edge,
  input wire logic fb_dir,
  input wire logic [15:0] fb_per_pitch,
  input wire logic scale_ref,
  input wire logic ref_dual,
  input wire logic scale_direct,
  input wire logic [31:0] scale_pitch_in,
  // motor
  input wire logic motor_present,
  input wire logic motor_enc_abs,
  input wire logic [15:0] motor_speed,
  // power stage requests and grants
  input wire logic regen_req,
  input wire logic dyn_brake_req,
  input wire logic brake_req,
  output logic regen_en,
  output logic dyn_brake_en,
  output logic brake_out,
  // utility function requests and grants
  input wire logic offset_adj_req,
  input wire logic origin_set_req,
  input wire logic polarity_req,
  input wire logic tuning_req,
  input wire logic vibration_req,
  output logic offset_adj_ok,
  output logic origin_set_ok,
  output logic polarity_ok,
  output logic tuning_ok,
  output logic vibration_ok,
  // host side outputs
  output logic quad_out_a,
  output logic quad_out_b,
  output logic origin_out,
  output logic enc_abs_sel,
  output logic test_active
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // true when res * spd * 100 exceeds pitch * 72
  function automatic logic over_lim(input logic [12:0] res, input logic [15:0] spd,
                                    input logic [31:0] pitch);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = 48'(res) * 48'(spd) * `LIM_DIV;
    rhs = 48'(pitch) * `LIM_MUL;
    return lhs > rhs;
  endfunction

  logic [7:0] aw_addr_q;
  logic aw_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_be_q;
  logic w_full_q;
  logic do_write;
  logic do_read;
  logic restart;
  logic [12:0] res_stage_q;
  logic [15:0] pitch_stage_q;
  logic [15:0] spd_stage_q;
  logic [15:0] cfg_stage_q;
  logic [12:0] res_act_q;
  logic [15:0] pitch_act_q;
  logic [15:0] spd_act_q;
  logic test_en_q;
  logic sim_abs_q;
  logic [1:0] sts_q;
  logic [1:0] mask_q;
  logic [31:0] pitch_eff;
  logic [15:0] spd_eff;
  logic set_alarm;
  logic ovs;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [16:0] acc_q;
  logic [16:0] acc_sum;
  logic step;
  logic [1:0] ph_q;
  logic [1:0] ph_step;
  logic ref_seen_q;
  logic ref_dir_q;
  logic org_edges_q;
  org_state_t org_q;

  // write channel
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  assign restart = do_write && aw_addr_q == `A_CTRL && w_be_q[0] && w_data_q[0];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (do_write)
      aw_full_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_be_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_be_q <= s_axi_wstrb;
    end
    else if (do_write)
      w_full_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OK;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q <= `A_MASK && aw_addr_q != `A_STATUS
                      && aw_addr_q[1:0] == 2'h0) ? `RESP_OK : `RESP_ERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // staged settings, used only after a restart; the interrupt mask takes effect at once
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      res_stage_q <= `RES_RST;
      pitch_stage_q <= `PITCH_RST;
      spd_stage_q <= `MAXSPD_RST;
      cfg_stage_q <= `TESTCFG_RST;
      mask_q <= 2'h0;
    end
    else if (do_write)
    begin
      unique case (aw_addr_q)
        `A_RES: res_stage_q <= 13'(merge(32'(res_stage_q), w_data_q, w_be_q));
        `A_PITCH: pitch_stage_q <= 16'(merge(32'(pitch_stage_q), w_data_q, w_be_q));
        `A_MAXSPD: spd_stage_q <= 16'(merge(32'(spd_stage_q), w_data_q, w_be_q));
        `A_TESTCFG: cfg_stage_q <= 16'(merge(32'(cfg_stage_q), w_data_q, w_be_q));
        `A_MASK: mask_q <= 2'(merge(32'(mask_q), w_data_q, w_be_q));
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      res_act_q <= `RES_RST; // RULE1
      pitch_act_q <= `PITCH_RST;
      spd_act_q <= `MAXSPD_RST;
      test_en_q <= 1'b0;
      sim_abs_q <= 1'b0;
    end
    else if (restart)
    begin
      res_act_q <= res_stage_q; // RULE1
      pitch_act_q <= pitch_stage_q;
      spd_act_q <= spd_stage_q;
      test_en_q <= cfg_stage_q[3:0] == 4'h1; // RULE11
      sim_abs_q <= cfg_stage_q[11:8] == 4'h1; // RULE12
    end
  end

  // limit checks
  assign pitch_eff = scale_direct ? scale_pitch_in : 32'(pitch_act_q); // RULE9
  assign spd_eff = (pitch_eff == `PITCH_4UM && spd_act_q > `SPD_CAP_4UM) ?
                   `SPD_CAP_4UM : spd_act_q; // RULE10
  assign set_alarm = res_act_q < `RES_MIN || res_act_q > `RES_MAX // RULE4
                     || over_lim(res_act_q, spd_eff, pitch_eff); // RULE3
  assign ovs = over_lim(res_act_q, motor_speed, pitch_eff); // RULE5

  // read channel
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `A_CTRL: rd_val = 32'h0000_0000;
      `A_RES: rd_val = 32'(res_stage_q);
      `A_PITCH: rd_val = 32'(pitch_stage_q);
      `A_MAXSPD: rd_val = 32'(spd_stage_q);
      `A_TESTCFG: rd_val = 32'(cfg_stage_q);
      `A_STATUS: rd_val = 32'(sts_q);
      `A_MASK: rd_val = 32'(mask_q);
      `A_STATE: rd_val = {16'(res_act_q), 10'h000, enc_abs_sel, test_active,
                          ovs, set_alarm, origin_out, 1'b0};
      `A_PMON_LO: rd_val = {16'h0000, pitch_eff[15:0]}; // RULE9
      `A_PMON_HI: rd_val = {16'h0000, pitch_eff[31:16]};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OK;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? `RESP_OK : `RESP_ERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // sticky status, a new event wins over the read clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      sts_q <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == `ST_SET && set_alarm) || (i == `ST_OVS && ovs && !set_alarm))
          sts_q[i] <= 1'b1;
        else if (do_read && s_axi_araddr == `A_STATUS)
          sts_q[i] <= 1'b0;
      end
    end
  end

  assign irq = |(sts_q & mask_q);

  // divider: each scale edge adds the resolution, overflow gives one output edge
  assign acc_sum = acc_q + 17'(res_act_q); // RULE2
  assign step = fb_edge && !set_alarm && acc_sum >= 17'(fb_per_pitch); // RULE7
  assign ph_step = fb_dir ? ph_q - 2'h1 : ph_q + 2'h1;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || restart || set_alarm)
      acc_q <= 17'h0_0000; // RULE18
    else if (fb_edge)
      acc_q <= step ? acc_sum - 17'(fb_per_pitch) : acc_sum; // RULE2
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ph_q <= 2'h0;
    else if (step)
      ph_q <= ph_step; // RULE16
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      quad_out_a <= 1'b0;
      quad_out_b <= 1'b0;
    end
    else if (step)
    begin
      quad_out_a <= ph_step[1]; // RULE16
      quad_out_b <= ph_step[1] ^ ph_step[0];
    end
  end

  // origin: first pass direction kept; dual zero point accepts both directions
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ref_seen_q <= 1'b0;
      ref_dir_q <= 1'b0;
    end
    else if (scale_ref && !ref_seen_q)
    begin
      ref_seen_q <= 1'b1;
      ref_dir_q <= fb_dir;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      org_q <= ORG_IDLE;
      org_edges_q <= 1'b0;
      origin_out <= 1'b0;
    end
    else
    begin
      unique case (org_q)
        ORG_IDLE:
          if (scale_ref && !set_alarm && (ref_dual || !ref_seen_q || fb_dir == ref_dir_q))
          begin
            org_q <= ORG_ACTIVE; // RULE8
            org_edges_q <= 1'b0;
            origin_out <= 1'b1;
          end
        ORG_ACTIVE:
          if (set_alarm || (step && org_edges_q))
          begin
            org_q <= ORG_IDLE; // RULE17
            origin_out <= 1'b0;
          end
          else if (step)
            org_edges_q <= 1'b1;
      endcase
    end
  end

  // motorless test gating
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      test_active <= 1'b0;
      enc_abs_sel <= 1'b0;
      regen_en <= 1'b0;
      dyn_brake_en <= 1'b0;
      brake_out <= 1'b0;
      offset_adj_ok <= 1'b0;
      origin_set_ok <= 1'b0;
      polarity_ok <= 1'b0;
      tuning_ok <= 1'b0;
      vibration_ok <= 1'b0;
    end
    else
    begin
      test_active <= test_en_q;
      enc_abs_sel <= (test_en_q && !motor_present) ? sim_abs_q : motor_enc_abs; // RULE13
      regen_en <= regen_req && !test_en_q; // RULE14
      dyn_brake_en <= dyn_brake_req && !test_en_q;
      brake_out <= brake_req && !test_en_q;
      offset_adj_ok <= offset_adj_req && !(test_en_q && !motor_present); // RULE15
      origin_set_ok <= origin_set_req && !(test_en_q && !motor_present);
      polarity_ok <= polarity_req && !test_en_q;
      tuning_ok <= tuning_req && !test_en_q;
      vibration_ok <= vibration_req && !test_en_q;
    end
  end

  // checks
  sequence s_restart;
    restart ##1 1'b1;
  endsequence

  a_restart_latch: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    s_restart |-> res_act_q == $past(res_stage_q))
    else $error("resolution not latched at restart");
  a_res_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    !restart |=> res_act_q == $past(res_act_q))
    else $error("resolution changed without restart");
  a_quad_gray: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE16
    $past(rst_n) |-> !($changed(quad_out_a) && $changed(quad_out_b)))
    else $error("both quadrature phases changed together");
  a_edge_cause: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
    $changed(ph_q) |-> $past(fb_edge) && !$past(set_alarm))
    else $error("output edge without scale edge");
  a_alarm_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE18
    set_alarm |=> $stable({quad_out_a, quad_out_b}) && acc_q == 17'h0_0000)
    else $error("outputs moved during setting alarm");
  a_example_limit: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
    (pitch_eff == 32'h0000_07d0 && spd_eff == 16'h0032)
    |-> set_alarm == (res_act_q > 13'h001c || res_act_q == 13'h0000))
    else $error("limit example not met");
  a_ovs_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
    ovs && !set_alarm |=> sts_q[`ST_OVS] ##1 1'b1)
    else $error("overspeed not recorded");
  a_test_inhibit: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
    test_en_q |=> !regen_en && !dyn_brake_en && !brake_out)
    else $error("power stage active during test");
  a_refuse_tune: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE15
    test_en_q && (polarity_req || tuning_req) |=> !polarity_ok && !tuning_ok)
    else $error("tuning granted during test");
  a_sim_type: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE13
    motor_present |=> enc_abs_sel == $past(motor_enc_abs))
    else $error("simulated type used with motor present");
  a_origin_width: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE17
    origin_out && !step && !set_alarm |=> origin_out)
    else $error("origin pulse ended early");

endmodule
`default_nettype wire

// ### testbench/host_quad_rx.sv
// host controller model: decodes the quadrature pair and the origin pulse
// assumes the block drives its host outputs registered on ref_clk
`timescale 1ns/100ps
`default_nettype none
module host_quad_rx (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host side of the block
  input wire logic quad_out_a,
  input wire logic quad_out_b,
  input wire logic origin_out,
  // decoded results
  output var int pos,
  output var int bad_steps,
  output var int origin_count,
  output var int origin_width,
  output var int a_width
);
  logic [1:0] ab_q;
  logic org_q;
  logic a_q;
  int a_run;
  int o_run;
  int d;
  function automatic int idx(input logic [1:0] v);
    return {v[1], v[0] ^ v[1]};
  endfunction
  // position follows each quadrature step, a double step counts as bad
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ab_q <= 2'h0;
      pos <= 0;
      bad_steps <= 0;
    end
    else if ({quad_out_a, quad_out_b} != ab_q)
    begin
      d = (idx({quad_out_a, quad_out_b}) - idx(ab_q)) & 3;
      ab_q <= {quad_out_a, quad_out_b};
      if (d == 1)
        pos <= pos + 1;
      else if (d == 3)
        pos <= pos - 1;
      else
        bad_steps <= bad_steps + 1;
    end
  end
  // widths of the last origin pulse and the last phase a pulse
  always @(posedge ref_clk)
  begin
    org_q <= origin_out;
    a_q <= quad_out_a;
    a_run <= quad_out_a ? a_run + 1 : 0;
    o_run <= origin_out ? o_run + 1 : 0;
    if (!rst_n)
      origin_count <= 0;
    else if (origin_out && !org_q)
      origin_count <= origin_count + 1;
    if (org_q && !origin_out)
      origin_width <= o_run;
    if (a_q && !quad_out_a)
      a_width <= a_run;
  end
endmodule
`default_nettype wire

// ### testbench/test_encoder_pulse_divider_motorless_test.sv
// self-checking bench of the encoder pulse divider with its host model
// assumes the design header and package are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "enc_div_defines.svh"
module test_encoder_pulse_divider_motorless_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic fb_edge = 1'b0, fb_dir = 1'b0, scale_ref = 1'b0, ref_dual = 1'b0, scale_direct = 1'b0;
  logic [15:0] fb_per_pitch = 16'h0014;
  logic [31:0] scale_pitch_in = 32'h0;
  logic motor_present = 1'b0, motor_enc_abs = 1'b0;
  logic [15:0] motor_speed = 16'h0;
  logic regen_req = 1'b0, dyn_brake_req = 1'b0, brake_req = 1'b0;
  logic offset_adj_req = 1'b0, origin_set_req = 1'b0, polarity_req = 1'b0;
  logic tuning_req = 1'b0, vibration_req = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic regen_en, dyn_brake_en, brake_out, offset_adj_ok, origin_set_ok, polarity_ok;
  logic tuning_ok, vibration_ok, quad_out_a, quad_out_b, origin_out, enc_abs_sel, test_active;
  logic [9:0] outs;
  logic [31:0] rnd_q = 32'h4abc;
  int pos, bad_steps, origin_count, origin_width, a_width;
  int num_errors = 0;
  int checks = 0;
  int p0, spd;
  int tr[7] = '{28, 29, 0, 4097, 4096, 20, 29};
  int tp[7] = '{2000, 2000, 2000, 2000, 2000, 400, 400};
  assign outs = {test_active, enc_abs_sel, regen_en, dyn_brake_en, brake_out, offset_adj_ok,
    origin_set_ok, polarity_ok, tuning_ok, vibration_ok};
  always #5 ref_clk = ~ref_clk;
  enc_div enc_div_inst (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq), .fb_edge(fb_edge), .fb_dir(fb_dir),
    .fb_per_pitch(fb_per_pitch), .scale_ref(scale_ref), .ref_dual(ref_dual),
    .scale_direct(scale_direct), .scale_pitch_in(scale_pitch_in), .motor_present(motor_present),
    .motor_enc_abs(motor_enc_abs), .motor_speed(motor_speed), .regen_req(regen_req),
    .dyn_brake_req(dyn_brake_req), .brake_req(brake_req), .regen_en(regen_en),
    .dyn_brake_en(dyn_brake_en), .brake_out(brake_out), .offset_adj_req(offset_adj_req),
    .origin_set_req(origin_set_req), .polarity_req(polarity_req), .tuning_req(tuning_req),
    .vibration_req(vibration_req), .offset_adj_ok(offset_adj_ok), .origin_set_ok(origin_set_ok),
    .polarity_ok(polarity_ok), .tuning_ok(tuning_ok), .vibration_ok(vibration_ok),
    .quad_out_a(quad_out_a), .quad_out_b(quad_out_b), .origin_out(origin_out),
    .enc_abs_sel(enc_abs_sel), .test_active(test_active));
  host_quad_rx host_quad_rx_inst (.ref_clk(ref_clk), .rst_n(rst_n), .quad_out_a(quad_out_a),
    .quad_out_b(quad_out_b), .origin_out(origin_out), .pos(pos), .bad_steps(bad_steps),
    .origin_count(origin_count), .origin_width(origin_width), .a_width(a_width));
  function logic [31:0] xs();
    rnd_q = rnd_q ^ (rnd_q << 13);
    rnd_q = rnd_q ^ (rnd_q >> 17);
    rnd_q = rnd_q ^ (rnd_q << 5);
    return rnd_q;
  endfunction
  // setting alarm of the reference model, speed capped for the fine pitch
  function automatic logic exp_alarm(input int r, input int p, input int s);
    int sc;
    sc = (p == `PITCH_4UM && s > `SPD_CAP_4UM) ? `SPD_CAP_4UM : s;
    return (r < 1 || r > 4096 || r * sc * 100 > p * 72);
  endfunction
  // expected grants with every request held high
  function automatic logic [9:0] exp_fn(input logic t, input logic ac, input logic mp,
    input logic ma);
    return {t, mp ? ma : ac, !t, !t, !t, !t || mp, !t || mp, !t, !t, !t};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic got;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    got = 1'b0;
    while (!got && n < 200)
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        got = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
    if (!got)
      num_errors++;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, `RESP_OK);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
    input logic [31:0] m);
    int n;
    logic got;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    got = 1'b0;
    while (!got && n < 200)
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        chk(s_axi_rdata & m, e & m);
        chk(s_axi_rresp, er);
        got = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
    if (!got)
      num_errors++;
  endtask
  task automatic restart();
    w(`A_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic edges(input int n, input logic dir, input int ref_at);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      fb_edge <= 1'b1;
      fb_dir <= dir;
      scale_ref <= (i == ref_at);
      @(posedge ref_clk);
      fb_edge <= 1'b0;
      scale_ref <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    results();
  end
  initial
  begin
    logic [1:0] r;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({quad_out_a, quad_out_b, origin_out, test_active, irq}, 0);
    rc(`A_RES, 20, `RESP_OK, 32'h1fff);
    rc(`A_PITCH, 2000, `RESP_OK, 32'hffff);
    rc(`A_MAXSPD, 50, `RESP_OK, 32'hffff);
    rc(`A_TESTCFG, 0, `RESP_OK, 32'hffff);
    rc(`A_STATE, 20 << 16, `RESP_OK, 32'hffff003e);
    rc(8'h40, 0, `RESP_ERR, 32'hffffffff);
    wr(`A_STATUS, 32'h1, r);
    chk(r, `RESP_ERR);
    $display("test reset done");
    p0 = pos;
    edges(20, 1'b0, 4);
    chk(pos - p0, 20);
    chk(bad_steps, 0);
    chk(origin_count, 1);
    chk(origin_width, a_width);
    chk(origin_width, 4);
    edges(20, 1'b1, 4);
    chk(pos - p0, 0);
    chk(origin_count, 1);
    ref_dual <= 1'b1;
    edges(20, 1'b1, 4);
    chk(origin_count, 2);
    w(`A_RES, 10);
    rc(`A_STATE, 20 << 16, `RESP_OK, 32'hffff0000);
    restart();
    rc(`A_STATE, 10 << 16, `RESP_OK, 32'hffff0000);
    p0 = pos;
    edges(40, 1'b0, -1);
    chk(pos - p0, 40 * 10 / 20);
    chk(bad_steps, 0);
    $display("test quadrature done");
    for (int i = 0; i < 7; i++)
    begin
      w(`A_RES, tr[i]);
      w(`A_PITCH, tp[i]);
      w(`A_MAXSPD, 50);
      restart();
      rc(`A_STATE, exp_alarm(tr[i], tp[i], 50) << 2, `RESP_OK, 32'h4);
    end
    p0 = pos;
    edges(8, 1'b0, -1);
    chk(pos - p0, 0);
    w(`A_MASK, 32'h1);
    chk(irq, 1'b1);
    w(`A_MASK, 32'h0);
    chk(irq, 1'b0);
    w(`A_RES, 20);
    w(`A_PITCH, 2000);
    restart();
    rc(`A_STATUS, 1, `RESP_OK, 32'h1);
    rc(`A_STATUS, 0, `RESP_OK, 32'h3);
    $display("test setting alarm done");
    w(`A_MASK, 32'h2);
    for (int i = 0; i < 8; i++)
    begin
      spd = (i < 2) ? 72 + i : xs() % 145;
      motor_speed <= spd[15:0];
      repeat (4) @(posedge ref_clk);
      rc(`A_STATE, (spd * 20 * 100 > 2000 * 72) << 3, `RESP_OK, 32'h8);
    end
    motor_speed <= 16'd100;
    repeat (4) @(posedge ref_clk);
    chk(irq, 1'b1);
    motor_speed <= 16'd0;
    repeat (4) @(posedge ref_clk);
    rc(`A_STATUS, 2, `RESP_OK, 32'h3);
    rc(`A_STATUS, 0, `RESP_OK, 32'h3);
    chk(irq, 1'b0);
    $display("test overspeed done");
    {regen_req, dyn_brake_req, brake_req, offset_adj_req} <= 4'hf;
    {origin_set_req, polarity_req, tuning_req, vibration_req} <= 4'hf;
    w(`A_TESTCFG, 32'h0101);
    repeat (3) @(posedge ref_clk);
    chk(test_active, 1'b0);
    restart();
    chk(outs, exp_fn(1'b1, 1'b1, 1'b0, 1'b0));
    motor_present <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(outs, exp_fn(1'b1, 1'b1, 1'b1, 1'b0));
    motor_present <= 1'b0;
    w(`A_TESTCFG, 32'h0001);
    restart();
    chk(outs, exp_fn(1'b1, 1'b0, 1'b0, 1'b0));
    w(`A_TESTCFG, 32'h0000);
    restart();
    chk(outs & 10'h2ff, exp_fn(1'b0, 1'b0, 1'b0, 1'b0) & 10'h2ff);
    $display("test motorless done");
    scale_direct <= 1'b1;
    scale_pitch_in <= 32'h0001_2345;
    w(`A_RES, 29);
    restart();
    rc(`A_PMON_LO, 32'h2345, `RESP_OK, 32'hffff);
    rc(`A_PMON_HI, 32'h0001, `RESP_OK, 32'hffff);
    rc(`A_STATE, exp_alarm(29, 32'h12345, 50) << 2, `RESP_OK, 32'h4);
    $display("test direct scale done");
    results();
  end
endmodule
`default_nettype wire
